// ### rtl/rx_status_pkg.sv
package rx_status_pkg;
   // APB register byte offsets
   localparam logic [7:0] OFF_STATUS_A = 8'h00;
   localparam logic [7:0] OFF_CONTROL_B = 8'h04;
   localparam logic [7:0] OFF_CONTROL_C = 8'h08;
   localparam logic [7:0] OFF_DATA = 8'h0c;
   localparam logic [7:0] OFF_BAUD = 8'h10;
   // status_reg_a bit positions
   localparam int ST_PARITY_ERR = 2;
   localparam int ST_OVERRUN = 3;
   localparam int ST_FRAME_ERR = 4;
   localparam int ST_COMPLETE = 7;
   localparam int ST_DOUBLE_SPEED = 1;
   // control_reg_b bit positions
   localparam int CB_NINTH_BIT = 1;
   localparam int CB_SIZE2 = 2;
   localparam int CB_RX_ENABLE = 4;
   localparam int CB_COMPLETE_IRQ_EN = 7;
   // control_reg_c bit positions
   localparam int CC_SIZE0 = 1;
   localparam int CC_TWO_STOP = 3;
   localparam int CC_PARITY_ODD = 4;
   localparam int CC_PARITY_EN = 5;
   // Reset values
   localparam logic [7:0] RST_CONTROL_B = 8'h00;
   localparam logic [7:0] RST_CONTROL_C = 8'h06;
   localparam logic [11:0] RST_BAUD = 12'h000;
   // Oversampling counts and voting samples
   localparam logic [3:0] LAST_SAMPLE_NORM = 4'hf;
   localparam logic [3:0] LAST_SAMPLE_DBL = 4'h7;
   localparam logic [3:0] VOTE_FIRST_NORM = 4'h7;
   localparam logic [3:0] VOTE_FIRST_DBL = 4'h3;
   // Buffer depth
   localparam int BUF_DEPTH = 2;
endpackage

// ### rtl/uart_receive_buffer_status.sv
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Complete flag set while unread characters exist
// - Receiver disable flushes the buffer
// - Interrupt request while enabled and complete
// - Data read pops oldest, advances status
// - Error flags buffered with each character
// - Status writes leave error flags unchanged
// - Error flags never raise interrupts
// - Frame error reflects first stop bit
// - Only first stop bit is checked
// - Overrun: buffer full, shifter full, start
// - Overrun tagged on next stored character
// - Overrun cleared on successful buffer transfer
// - Parity check enabled, odd/even selectable
// - Parity mismatch stored with character
// - Parity error only when enabled then
// - Parity error zero when checking disabled
// - Disable abandons frame in progress immediately
// - Disabled receiver releases the pin
// - Sixteen or eight samples per bit
// - Clock recovery aligns, majority vote filters
// - Enable takes over the input pin
// - Unused high data bits read zero
// - Ninth bit buffered per character
//////////////////////////////////////////////////////////////////////////////
module uart_receive_buffer_status
#(
   parameter int BAUD_W = 12
)
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic global_irq_enable_i,
   input wire logic serial_input_pin_i,
   output logic pin_taken_o,
   output logic rx_irq_o
);

   typedef enum logic [1:0] {IDLE, START, BITS} rx_state_t;

   typedef struct packed {
      logic [8:0] data;
      logic frame_err;
      logic overrun;
      logic parity_err;
   } entry_t;

   logic [7:0] control_b;
   logic [7:0] control_c;
   logic double_speed;
   logic [BAUD_W-1:0] baud_div;
   logic [BAUD_W-1:0] tick_cnt;
   logic tick;
   logic sync1;
   logic sync2;
   logic [2:0] votes;
   rx_state_t state;
   logic [3:0] sample;
   logic [3:0] bit_idx;
   logic [9:0] shreg;
   logic shift_full;
   entry_t shift_entry;
   entry_t buf_mem [rx_status_pkg::BUF_DEPTH];
   logic rd_ptr;
   logic wr_ptr;
   logic [1:0] count;
   logic lost;
   logic rx_en;
   logic [3:0] last_sample;
   logic [3:0] vote_first;
   logic bit_val;
   logic [3:0] n_data;
   logic [3:0] n_total;
   logic wr_acc;
   logic rd_acc;
   logic pop;
   logic push;
   logic start_seen;
   entry_t head;

   //////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic majority(input logic [2:0] v);
      return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction

   function automatic logic [3:0] data_bits(input logic [2:0] sz);
      return (sz == 3'h7) ? 4'h9 : (4'h5 + {2'h0, sz[1:0]});
   endfunction

   assign rx_en = control_b[rx_status_pkg::CB_RX_ENABLE];
   // Per-bit sample counts follow the speed selection
   assign last_sample = double_speed ? rx_status_pkg::LAST_SAMPLE_DBL :
      rx_status_pkg::LAST_SAMPLE_NORM;
   assign vote_first = double_speed ? rx_status_pkg::VOTE_FIRST_DBL :
      rx_status_pkg::VOTE_FIRST_NORM;
   assign n_data = data_bits({control_b[rx_status_pkg::CB_SIZE2],
      control_c[rx_status_pkg::CC_SIZE0 +: 2]});
   assign n_total = n_data + {3'h0, control_c[rx_status_pkg::CC_PARITY_EN]};
   assign head = buf_mem[rd_ptr];
   assign wr_acc = psel_i & penable_i & pwrite_i;
   assign rd_acc = psel_i & penable_i & ~pwrite_i;
   assign pop = rd_acc & (paddr_i == rx_status_pkg::OFF_DATA) & (count != 2'h0);
   assign pready_o = 1'b1;
   assign pslverr_o = 1'b0;
   assign pin_taken_o = rx_en;

   //////////////////////////////////////////////////////////////////////////
   // Control registers, writable over APB
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         control_b <= rx_status_pkg::RST_CONTROL_B;
         control_c <= rx_status_pkg::RST_CONTROL_C;
         baud_div <= rx_status_pkg::RST_BAUD[BAUD_W-1:0];
         double_speed <= 1'b0;
      end
      else if (wr_acc)
      begin
         unique case (paddr_i)
            rx_status_pkg::OFF_CONTROL_B: control_b <= pwdata_i[7:0] & 8'hfd; // Ninth bit read-only
            rx_status_pkg::OFF_CONTROL_C: control_c <= pwdata_i[7:0];
            rx_status_pkg::OFF_BAUD: baud_div <= pwdata_i[BAUD_W-1:0];
            // Error flag positions ignored on write
            rx_status_pkg::OFF_STATUS_A:
               double_speed <= pwdata_i[rx_status_pkg::ST_DOUBLE_SPEED];
            default: ;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Read data mux
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         prdata_o <= 32'h0000_0000;
      else if (psel_i & ~penable_i & ~pwrite_i)
      begin
         prdata_o <= 32'h0000_0000;
         unique case (paddr_i)
            rx_status_pkg::OFF_STATUS_A:
            begin
               prdata_o[rx_status_pkg::ST_COMPLETE] <= count != 2'h0;
               prdata_o[rx_status_pkg::ST_FRAME_ERR] <= head.frame_err & (count != 2'h0);
               prdata_o[rx_status_pkg::ST_OVERRUN] <= head.overrun & (count != 2'h0);
               prdata_o[rx_status_pkg::ST_PARITY_ERR] <= head.parity_err & (count != 2'h0);
               prdata_o[rx_status_pkg::ST_DOUBLE_SPEED] <= double_speed;
            end
            rx_status_pkg::OFF_CONTROL_B:
               prdata_o[7:0] <= {control_b[7:2], head.data[8], control_b[0]};
            rx_status_pkg::OFF_CONTROL_C: prdata_o[7:0] <= control_c;
            rx_status_pkg::OFF_DATA: prdata_o[7:0] <= head.data[7:0];
            rx_status_pkg::OFF_BAUD: prdata_o[BAUD_W-1:0] <= baud_div;
            default: ;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Oversample tick from baud divider
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end
      else if (tick_cnt >= baud_div)
      begin
         tick_cnt <= '0;
         tick <= 1'b1;
      end
      else
      begin
         tick_cnt <= tick_cnt + 1'b1;
         tick <= 1'b0;
      end
   end

   // Pin synchroniser
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
      end
      else
      begin
         sync1 <= serial_input_pin_i;
         sync2 <= sync1;
      end
   end

   assign bit_val = majority(votes);

   //////////////////////////////////////////////////////////////////////////
   // Clock and data recovery state machine
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state <= IDLE;
         sample <= 4'h0;
         bit_idx <= 4'h0;
         shreg <= 10'h000;
         votes <= 3'h7;
         shift_full <= 1'b0;
         shift_entry <= '0;
         start_seen <= 1'b0;
      end
      else if (!rx_en)
      begin
         state <= IDLE;
         shift_full <= 1'b0;
         start_seen <= 1'b0;
      end
      else
      begin
         start_seen <= 1'b0;
         if (push)
            shift_full <= 1'b0;
         if (tick)
         begin
            if (sample >= vote_first && sample <= vote_first + 4'h2)
               votes <= {votes[1:0], sync2};
            unique case (state)
               IDLE:
                  if (!sync2)
                  begin
                     state <= START;
                     sample <= 4'h1;
                     start_seen <= 1'b1;
                  end
               START:
               begin
                  sample <= sample + 4'h1;
                  if (sample == vote_first + 4'h3)
                  begin
                     if (bit_val)
                        state <= IDLE; // Noise spike rejected
                  end
                  else if (sample == last_sample)
                  begin
                     state <= BITS;
                     sample <= 4'h0;
                     bit_idx <= 4'h0;
                  end
               end
               BITS:
               begin
                  sample <= sample + 4'h1;
                  if (sample == vote_first + 4'h3)
                  begin
                     if (bit_idx < n_total)
                     begin
                        shreg[bit_idx] <= bit_val;
                        bit_idx <= bit_idx + 4'h1;
                     end
                     else
                     begin
                        // First stop bit ends the frame
                        state <= IDLE;
                        shift_full <= 1'b1;
                        shift_entry.data <= shreg[8:0] & ~(9'h1ff << n_data);
                        shift_entry.frame_err <= ~bit_val;
                        // Flag forced low while checking is off
                        shift_entry.parity_err <=
                           control_c[rx_status_pkg::CC_PARITY_EN] &
                           ((^(shreg[8:0] & ~(9'h1ff << n_data))) ^ shreg[n_data] ^
                           control_c[rx_status_pkg::CC_PARITY_ODD]);
                        sample <= 4'h0;
                     end
                  end
                  else if (sample == last_sample)
                     sample <= 4'h0;
               end
            endcase
         end
      end
   end

   assign push = shift_full & ((count != 2'(rx_status_pkg::BUF_DEPTH)) | pop);

   //////////////////////////////////////////////////////////////////////////
   // Overrun tracking
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         lost <= 1'b0;
      else if (!rx_en)
         lost <= 1'b0;
      else if (start_seen & shift_full & (count == 2'(rx_status_pkg::BUF_DEPTH)) & ~pop)
         lost <= 1'b1;
      else if (push)
         lost <= 1'b0;
   end

   //////////////////////////////////////////////////////////////////////////
   // Two-entry receive buffer
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
         count <= 2'h0;
         buf_mem[0] <= '0;
         buf_mem[1] <= '0;
      end
      else if (!rx_en)
      begin
         count <= 2'h0;
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            buf_mem[wr_ptr] <= shift_entry;
            buf_mem[wr_ptr].overrun <= lost;
            wr_ptr <= ~wr_ptr;
         end
         if (pop)
            rd_ptr <= ~rd_ptr;
         count <= count + 2'(push) - 2'(pop);
      end
   end

   // Only receive-complete drives the interrupt
   assign rx_irq_o = control_b[rx_status_pkg::CB_COMPLETE_IRQ_EN] & (count != 2'h0) &
      global_irq_enable_i;

   //////////////////////////////////////////////////////////////////////////
   // Checks
   a_flush_empties: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !rx_en |=> count == 2'h0)
      else $error("buffer not flushed on disable");
   a_irq_follows: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      rx_irq_o == (control_b[rx_status_pkg::CB_COMPLETE_IRQ_EN] & global_irq_enable_i &
      (count != 2'h0)))
      else $error("irq mismatch");
   a_count_bound: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      count <= 2'h2)
      else $error("buffer overfilled");
   a_pop_advance: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      pop & rx_en |=> rd_ptr != $past(rd_ptr))
      else $error("read did not advance");
   a_parity_disabled: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      push & !control_c[rx_status_pkg::CC_PARITY_EN] |=> !buf_mem[$past(wr_ptr)].parity_err)
      else $error("parity flag without checking");
   a_overrun_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      push & rx_en |=> !lost)
      else $error("overrun not cleared");
   a_stop_abandon: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !rx_en |=> state == IDLE && !shift_full)
      else $error("frame not abandoned");
   a_pin_release: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      pin_taken_o == control_b[rx_status_pkg::CB_RX_ENABLE])
      else $error("pin ownership wrong");
   a_error_no_irq: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      rx_irq_o |-> count != 2'h0)
      else $error("interrupt without character");

endmodule

// ### verification/serial_tx_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
module serial_tx_model
(
   input wire logic clk_sys_i,
   output logic line_o
);
   // Line idles high between frames
   initial line_o = 1'b1;

   // Holds one level for one bit time
   task automatic bit_out(input logic v, input int bclk);
      line_o <= v;
      repeat (bclk) @(posedge clk_sys_i);
   endtask

   // Start, data low bit first, optional parity, one stop, idle bit
   task automatic send(input logic [8:0] d, input int nb, input int par,
      input bit bad, input bit stp, input int bclk);
      logic p;
      int i;
      p = (^(d & ((9'h001 << nb) - 9'h001))) ^ (par == 2) ^ bad;
      bit_out(1'b0, bclk);
      for (i = 0; i < nb; i++)
         bit_out(d[i], bclk);
      if (par != 0)
         bit_out(p, bclk);
      bit_out(stp, bclk);
      bit_out(1'b1, bclk);
   endtask
endmodule

// ### verification/testbench.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
module testbench;
   localparam logic [7:0] st_a = rx_status_pkg::OFF_STATUS_A;
   localparam logic [7:0] cb = rx_status_pkg::OFF_CONTROL_B;
   localparam logic [7:0] cc = rx_status_pkg::OFF_CONTROL_C;
   localparam logic [7:0] dat = rx_status_pkg::OFF_DATA;
   logic clk_sys_i, rst_n_i, psel, penable, pwrite, gie, line;
   logic pready, pslverr, pin_taken, rx_irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [63:0] exp_q[$];
   logic [63:0] e;
   logic [8:0] d;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   int bclk = 16;
   int k;

   // Free-running system clock
   initial
   begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end

   uart_receive_buffer_status uart_receive_buffer_status_inst (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .global_irq_enable_i(gie),
      .serial_input_pin_i(line), .pin_taken_o(pin_taken), .rx_irq_o(rx_irq));

   serial_tx_model serial_tx_model_inst (.clk_sys_i(clk_sys_i), .line_o(line));

   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] ex);
      comparisons++;
      if (got !== ex)
      begin
         $display("unexpected at %0t ns: got %h expected %h", $time, got, ex);
         miscompares++;
      end
   endtask

   task automatic complete_run();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // One APB transfer; reads leave their expectation in the queue
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      input logic [31:0] ex, input logic [31:0] m);
      if (!wr)
         exp_q.push_back({m, ex});
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      @(posedge clk_sys_i);
      while (pready !== 1'b1)
         @(posedge clk_sys_i);
      rdv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      apb(1'b1, a, v, 32'h0, 32'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m);
      apb(1'b0, a, 32'h0, ex, m);
   endtask

   // Status flags: complete, frame error, overrun, parity error
   task automatic rs(input bit c, input bit f, input bit o, input bit p);
      rd(st_a, {24'h0, c, 2'b00, f, o, p, 2'b00}, 32'h9c);
   endtask

   // Polls status until a character is waiting
   task automatic wait_rx();
      rdv = 32'h0;
      for (k = 0; k < 300 && rdv[7] !== 1'b1; k++)
         rd(st_a, 32'h0, 32'h0);
   endtask

   task automatic fr(input logic [8:0] v, input int nb, input int par,
      input bit bad, input bit stp);
      serial_tx_model_inst.send(v, nb, par, bad, stp, bclk);
   endtask

   ////////////////////////////////////////////////////////////
   // Compares each completed read against the oldest note
   always @(posedge clk_sys_i)
   begin
      if (psel && penable && pready === 1'b1 && !pwrite)
      begin
         e = exp_q.pop_front();
         chk(prdata & e[63:32], e[31:0] & e[63:32]);
      end
   end

   // Cuts a hung run short
   always @(posedge clk_sys_i)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         miscompares++;
         complete_run();
      end
   end

   ////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      void'($urandom(94));
      rst_n_i = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      gie = 1'b1;
      repeat (8) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      rd(cb, 32'h0, 32'hff);
      rd(cc, 32'h06, 32'hff);
      rs(0, 0, 0, 0);
      rd(8'h20, 32'h0, 32'hffffffff);
      chk({pready, pslverr}, 32'h2);
      chk(pin_taken, 1'b0);
      $display("test reset done");
      wr(rx_status_pkg::OFF_BAUD, 32'h1);
      bclk = 32;
      wr(cb, 32'h90);
      chk(pin_taken, 1'b1);
      d = 9'($urandom);
      fr(d, 8, 0, 0, 1);
      wait_rx();
      chk(rx_irq, 1'b1);
      gie <= 1'b0;
      @(posedge clk_sys_i);
      @(posedge clk_sys_i);
      chk(rx_irq, 1'b0);
      gie <= 1'b1;
      rs(1, 0, 0, 0);
      rd(dat, {24'h0, d[7:0]}, 32'hffffffff);
      rs(0, 0, 0, 0);
      chk(rx_irq, 1'b0);
      $display("test basic done");
      wr(cc, 32'h0e);
      wr(cb, 32'h10);
      fr(d, 8, 0, 0, 0);
      wait_rx();
      rs(1, 1, 0, 0);
      wr(st_a, 32'h0);
      rs(1, 1, 0, 0);
      chk(rx_irq, 1'b0);
      rd(dat, {24'h0, d[7:0]}, 32'hff);
      $display("test frame error done");
      for (int m = 0; m < 4; m++)
      begin
         d = 9'($urandom);
         wr(cc, 32'h26 | (m[1] << 4));
         fr(d, 8, 1 + m[1], m[0], 1);
         wait_rx();
         rs(1, 0, 0, m[0]);
         rd(dat, {24'h0, d[7:0]}, 32'hff);
      end
      $display("test parity done");
      wr(cc, 32'h06);
      for (int m = 0; m < 4; m++)
         fr(9'(m + 8'h40), 8, 0, 0, 1);
      rs(1, 0, 0, 0);
      rd(dat, 32'h40, 32'hff);
      rs(1, 0, 0, 0);
      rd(dat, 32'h41, 32'hff);
      rs(1, 0, 1, 0);
      rd(dat, 32'h0, 32'h0);
      for (int m = 0; m < 4; m++)
      begin
         rd(st_a, 32'h0, 32'h0);
         if (rdv[7] === 1'b1)
            rd(dat, 32'h0, 32'h0);
      end
      rs(0, 0, 0, 0);
      fr(9'h33, 8, 0, 0, 1);
      wait_rx();
      rs(1, 0, 0, 0);
      rd(dat, 32'h33, 32'hff);
      $display("test overrun done");
      wr(cc, 32'h00);
      d = 9'($urandom);
      fr(d, 5, 0, 0, 1);
      wait_rx();
      rd(dat, {27'h0, d[4:0]}, 32'hffffffff);
      wr(cb, 32'h14);
      wr(cc, 32'h06);
      fr(d, 9, 0, 0, 1);
      wait_rx();
      rd(cb, {30'h0, d[8], 1'b0}, 32'h2);
      rd(dat, {24'h0, d[7:0]}, 32'hff);
      wr(cb, 32'h10);
      $display("test sizes done");
      wr(st_a, 32'h02);
      bclk = 16;
      fr(d, 8, 0, 0, 1);
      wait_rx();
      rd(st_a, 32'h82, 32'h9e);
      rd(dat, {24'h0, d[7:0]}, 32'hff);
      wr(st_a, 32'h0);
      bclk = 32;
      $display("test double speed done");
      fr(9'h5a, 8, 0, 0, 1);
      wait_rx();
      fork
         fr(9'h3c, 8, 0, 0, 1);
         begin
            repeat (128) @(posedge clk_sys_i);
            wr(cb, 32'h0);
         end
      join
      chk(pin_taken, 1'b0);
      rs(0, 0, 0, 0);
      wr(cb, 32'h10);
      fr(9'h69, 8, 0, 0, 1);
      wait_rx();
      rd(dat, 32'h69, 32'hff);
      rs(0, 0, 0, 0);
      $display("test disable done");
      complete_run();
   end
endmodule
